/* File: common/uart_lsf_pkg.sv */
// Constants shared by the line status flag block and its queues.
// Assumes an 8-bit register port with a 3-bit word address.
package uart_lsf_pkg;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [2:0] OFF_DATA = 3'h0;
   localparam logic [2:0] OFF_LINE_STATUS = 3'h1;
   localparam logic [2:0] OFF_CTRL = 3'h2;
   localparam logic [2:0] OFF_INT_STATUS = 3'h3;
   localparam logic [2:0] OFF_INT_MASK = 3'h4;
   localparam logic [2:0] OFF_BIT_CYCLES = 3'h5;
   localparam logic [2:0] OFF_FRAME_BITS = 3'h6;

   // Line status bit positions, also used by interrupt status and mask
   localparam int LS_READY = 0;
   localparam int LS_OVERRUN = 1;
   localparam int LS_PARITY = 2;
   localparam int LS_FRAMING = 3;
   localparam int LS_BREAK = 4;
   localparam int LS_TX_EMPTY = 5;
   localparam int LS_ERR_SUM = 7;

   // Control register bit positions
   localparam int CTRL_QUEUE_EN = 0;
   localparam int CTRL_PARITY_EN = 1;
   localparam int CTRL_PARITY_EVEN = 2;

   // Receive queue entry layout
   localparam int ENT_PARITY = 8;
   localparam int ENT_FRAMING = 9;
   localparam int ENT_BREAK = 10;
   localparam int ENT_W = 11;

   // Values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] INT_MASK_RST = 8'h00;
   localparam logic [15:0] BIT_CYCLES_RST = 16'h043D;
   localparam logic [3:0] FRAME_BITS_RST = 4'hA;

   // Counts
   localparam int QUEUE_DEPTH = 64;
   localparam int FRAME_CNT_W = 20;

endpackage

/* File: common/queue_if.sv */
// Push and pop side of one character queue.
// Assumes one clock; the queue answers with level flags.
`timescale 1ns/100ps
interface queue_if #(parameter int WIDTH = 8);
   logic push;
   logic [WIDTH-1:0] push_data;
   logic pop;
   logic [WIDTH-1:0] head_data;
   logic empty;
   logic full;

   modport store (input push, push_data, pop, output head_data, empty, full);
   modport user (output push, push_data, pop, input head_data, empty, full);
endinterface

/* File: hw/char_queue.sv */
// Flip-flop queue of fixed depth with head-of-queue output.
// Assumes DEPTH is a power of two; push when full and pop when empty are ignored.
`timescale 1ns/100ps
module char_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = uart_lsf_pkg::QUEUE_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Queue port
   queue_if.store q
);
   import uart_lsf_pkg::*;

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] rd_ptr;
      logic [PW-1:0] wr_ptr;
      logic [PW:0] count;
   } queue_state_t;

   queue_state_t s_reg;
   queue_state_t s_next;
   logic do_push;
   logic do_pop;

   assign q.empty = (s_reg.count == '0);
   assign q.full = (s_reg.count == (PW + 1)'(DEPTH));
   assign q.head_data = s_reg.mem[s_reg.rd_ptr];
   assign do_push = q.push && !q.full;
   assign do_pop = q.pop && !q.empty;

   always_comb begin
      s_next = s_reg;
      if (do_push) begin
         s_next.mem[s_reg.wr_ptr] = q.push_data;
         s_next.wr_ptr = s_reg.wr_ptr + PW'(1);
      end
      if (do_pop) begin
         s_next.rd_ptr = s_reg.rd_ptr + PW'(1);
      end
      if (do_push && !do_pop) begin
         s_next.count = s_reg.count + (PW + 1)'(1);
      end else if (do_pop && !do_push) begin
         s_next.count = s_reg.count - (PW + 1)'(1);
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* File: hw/break_detect.sv */
// Serial line synchroniser and break detector.
// Assumes the receive pin is asynchronous to ref_clk_in and idles high.
`timescale 1ns/100ps
module break_detect (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Serial line
   input wire logic rx_serial_in,
   // Frame time in clock cycles
   input wire logic [uart_lsf_pkg::FRAME_CNT_W-1:0] frame_cycles_in,
   // One pulse per break
   output logic break_pulse_out
);
   import uart_lsf_pkg::*;

   typedef struct packed {
      logic [2:0] sync;
      logic line;
      logic [FRAME_CNT_W-1:0] count;
      logic fired;
      logic pulse;
   } brk_state_t;

   brk_state_t s_reg;
   brk_state_t s_next;
   logic [FRAME_CNT_W-1:0] count_inc;

   assign count_inc = s_reg.count + FRAME_CNT_W'(1);
   assign break_pulse_out = s_reg.pulse;

   always_comb begin
      s_next = s_reg;
      s_next.sync = {s_reg.sync[1:0], rx_serial_in};
      s_next.pulse = 1'b0;
      // A level change counts only once stages two and three agree
      if (s_reg.sync[1] == s_reg.sync[2]) begin
         s_next.line = s_reg.sync[2];
      end
      if (s_reg.line) begin
         s_next.count = '0;
         s_next.fired = 1'b0;
      end else if (!s_reg.fired) begin
         s_next.count = count_inc;
         if (count_inc >= frame_cycles_in) begin
            s_next.pulse = 1'b1;
            s_next.fired = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_reg <= '{sync: 3'h7, line: 1'b1, count: '0, fired: 1'b0, pulse: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* File: hw/uart_line_status_flags.sv */
// Line status flags of a serial transceiver with receive and transmit queues.
// Assumes external shifters: the receiver reports each finished character
// with its parity and stop bits, the transmitter takes a character when ready.
//
// How it works
// - Without queues, the transmit-empty flag rises when the held character moves to the shifter.
// - Without queues, a host write of a character drops the transmit-empty flag; a write in the cycle the held character moves to the shifter is lost.
// - With queues, the transmit-empty flag is high while the transmit queue is empty and drops on any write.
// - The interrupt output is high while the transmit-empty flag and its enable are both set.
// - The break flag is set when the serial line stays low for a whole frame time, else it reads zero.
// - With queues, each break condition loads one break character, however long it lasts, unless the receive queue is full, when it loads none.
// - The framing flag is set when a received character has no valid stop bit.
// - The parity flag is set when received parity disagrees with the configured parity.
// - With queues, parity and framing flags are stored per character and show only the head character.
// - The overrun flag is set when a character completes while the receive queue is full.
// - On overrun the new character is dropped so queued characters stay intact.
// - The ready flag is high while at least one received character is held.
// - After reset all error and ready flags read zero.
// - Bit 7 is set when any parity, framing or break mark enters the queue and cleared by a status read.
`timescale 1ns/100ps
module uart_line_status_flags #(
   parameter int QUEUE_DEPTH = uart_lsf_pkg::QUEUE_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [uart_lsf_pkg::ADDR_W-1:0] addr_in,
   input wire logic [uart_lsf_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [uart_lsf_pkg::DATA_W-1:0] rdata_out,
   // Serial receive pin
   input wire logic rx_serial_in,
   // Receive shifter
   input wire logic rx_done_in,
   input wire logic [7:0] rx_char_in,
   input wire logic rx_parity_bit_in,
   input wire logic rx_stop_bit_in,
   // Transmit shifter
   input wire logic tx_shift_ready_in,
   output logic tx_load_out,
   output logic [7:0] tx_char_out,
   // Interrupt
   output logic irq_out
);
   import uart_lsf_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] ctrl;
      logic [7:0] int_status;
      logic [7:0] int_mask;
      logic [15:0] bit_cycles;
      logic [3:0] frame_bits;
      logic overrun;
      logic err_sum;
      logic head_seen;
      logic tx_was_empty;
   } lsf_state_t;

   lsf_state_t s_reg;
   lsf_state_t s_next;

   queue_if #(.WIDTH(ENT_W)) rxq ();
   queue_if #(.WIDTH(8)) txq ();

   logic [FRAME_CNT_W-1:0] frame_cycles;
   logic break_pulse;
   logic queue_en;
   logic rx_full_eff;
   logic tx_full_eff;
   logic rx_req;
   logic overrun_ev;
   logic parity_bad;
   logic [ENT_W-1:0] new_entry;
   logic head_valid;
   logic [7:0] line_status;
   logic [7:0] events;
   logic rd_data;
   logic rd_status;
   logic wr_data;

   ////////////////////////////////////////////////////////////////////////
   // Queues and break detector

   char_queue #(
      .WIDTH(ENT_W),
      .DEPTH(QUEUE_DEPTH)
   ) rx_queue (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .q(rxq)
   );

   char_queue #(
      .WIDTH(8),
      .DEPTH(QUEUE_DEPTH)
   ) tx_queue (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .q(txq)
   );

   // Frame time follows the software bit time and frame length
   assign frame_cycles = FRAME_CNT_W'(s_reg.bit_cycles) * FRAME_CNT_W'(s_reg.frame_bits);

   break_detect brk (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .rx_serial_in(rx_serial_in),
      .frame_cycles_in(frame_cycles),
      .break_pulse_out(break_pulse)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register port decode

   assign rd_data = rd_in && (addr_in == OFF_DATA);
   assign rd_status = rd_in && (addr_in == OFF_LINE_STATUS);
   assign wr_data = wr_in && (addr_in == OFF_DATA);
   assign queue_en = s_reg.ctrl[CTRL_QUEUE_EN];

   ////////////////////////////////////////////////////////////////////////
   // Transmit side

   // Without queues the holding stage is one entry deep
   assign tx_full_eff = queue_en ? txq.full : !txq.empty;

   assign txq.push = wr_data && !tx_full_eff;
   assign txq.push_data = wdata_in;

   assign tx_load_out = !txq.empty && tx_shift_ready_in;
   assign txq.pop = tx_load_out;
   assign tx_char_out = txq.head_data;

   ////////////////////////////////////////////////////////////////////////
   // Receive side

   assign rx_full_eff = queue_en ? rxq.full : !rxq.empty;
   assign rx_req = rx_done_in || break_pulse;

   assign parity_bad = s_reg.ctrl[CTRL_PARITY_EN] &&
      ((^rx_char_in ^ rx_parity_bit_in) ^ !s_reg.ctrl[CTRL_PARITY_EVEN]);

   always_comb begin
      new_entry = '0;
      if (break_pulse) begin
         new_entry[ENT_BREAK] = 1'b1;
         new_entry[ENT_FRAMING] = 1'b1;
      end else begin
         new_entry[7:0] = rx_char_in;
         new_entry[ENT_FRAMING] = !rx_stop_bit_in;
         new_entry[ENT_PARITY] = parity_bad;
      end
   end

   assign rxq.push = rx_req && !rx_full_eff;
   assign rxq.push_data = new_entry;
   assign overrun_ev = rx_req && rx_full_eff;
   assign rxq.pop = rd_data && !rxq.empty;

   ////////////////////////////////////////////////////////////////////////
   // Line status word

   assign head_valid = !rxq.empty && !s_reg.head_seen;

   always_comb begin
      line_status = '0;
      line_status[LS_READY] = !rxq.empty;
      line_status[LS_OVERRUN] = s_reg.overrun;
      line_status[LS_PARITY] = head_valid && rxq.head_data[ENT_PARITY];
      line_status[LS_FRAMING] = head_valid && rxq.head_data[ENT_FRAMING];
      line_status[LS_BREAK] = head_valid && rxq.head_data[ENT_BREAK];
      line_status[LS_TX_EMPTY] = txq.empty;
      line_status[LS_ERR_SUM] = s_reg.err_sum;
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt events, same layout as the line status word

   always_comb begin
      events = '0;
      events[LS_READY] = rxq.push;
      events[LS_OVERRUN] = overrun_ev;
      events[LS_PARITY] = rxq.push && new_entry[ENT_PARITY];
      events[LS_FRAMING] = rxq.push && new_entry[ENT_FRAMING];
      events[LS_BREAK] = rxq.push && new_entry[ENT_BREAK];
      events[LS_TX_EMPTY] = txq.empty && !s_reg.tx_was_empty;
      events[LS_ERR_SUM] = rxq.push && (|new_entry[ENT_BREAK:ENT_PARITY]);
   end

   assign irq_out = (|(s_reg.int_status & s_reg.int_mask)) ||
      (txq.empty && s_reg.int_mask[LS_TX_EMPTY]);

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_next = s_reg;
      s_next.rdata = '0;
      s_next.tx_was_empty = txq.empty;

      // Read data stand for one cycle only; unmapped reads give zero
      if (rd_in) begin
         unique case (addr_in)
            OFF_DATA: s_next.rdata = rxq.empty ? 8'h00 : rxq.head_data[7:0];
            OFF_LINE_STATUS: s_next.rdata = line_status;
            OFF_CTRL: s_next.rdata = s_reg.ctrl;
            OFF_INT_STATUS: s_next.rdata = s_reg.int_status;
            OFF_INT_MASK: s_next.rdata = s_reg.int_mask;
            OFF_BIT_CYCLES: s_next.rdata = s_reg.bit_cycles[7:0];
            OFF_FRAME_BITS: s_next.rdata = {4'h0, s_reg.frame_bits};
            default: s_next.rdata = 8'h00;
         endcase
      end

      if (wr_in) begin
         unique case (addr_in)
            OFF_CTRL: s_next.ctrl = wdata_in;
            OFF_INT_MASK: s_next.int_mask = wdata_in;
            OFF_BIT_CYCLES: s_next.bit_cycles = {8'h00, wdata_in};
            OFF_FRAME_BITS: s_next.frame_bits = wdata_in[3:0];
            default: s_next.ctrl = s_reg.ctrl;
         endcase
      end

      // Write one to clear; a new event in the same cycle wins
      if (wr_in && (addr_in == OFF_INT_STATUS)) begin
         s_next.int_status = (s_reg.int_status & ~wdata_in) | events;
      end else begin
         s_next.int_status = s_reg.int_status | events;
      end

      if (rd_status) begin
         s_next.overrun = 1'b0;
         s_next.err_sum = 1'b0;
         s_next.head_seen = !rxq.empty;
      end
      // A new head character brings its own flags
      if (rxq.pop) begin
         s_next.head_seen = 1'b0;
      end

      if (overrun_ev) begin
         s_next.overrun = 1'b1;
      end
      if (events[LS_ERR_SUM]) begin
         s_next.err_sum = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   assign rdata_out = s_reg.rdata;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_reg <= '{
            rdata: 8'h00,
            ctrl: CTRL_RST,
            int_status: 8'h00,
            int_mask: INT_MASK_RST,
            bit_cycles: BIT_CYCLES_RST,
            frame_bits: FRAME_BITS_RST,
            overrun: 1'b0,
            err_sum: 1'b0,
            head_seen: 1'b0,
            tx_was_empty: 1'b1
         };
      end else begin
         s_reg <= s_next;
      end
   end
endmodule

/* File: dv/uart_lsf_checker.sv */
// Port-level checks of the line status flag block.
// Assumes one clock domain; bound to the top module.
`timescale 1ns/100ps
module uart_lsf_checker #(
   parameter int QUEUE_DEPTH = uart_lsf_pkg::QUEUE_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Register port
   input wire logic [uart_lsf_pkg::ADDR_W-1:0] addr_in,
   input wire logic [uart_lsf_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [uart_lsf_pkg::DATA_W-1:0] rdata_out,
   // Shifters and interrupt
   input wire logic rx_done_in,
   input wire logic tx_shift_ready_in,
   input wire logic tx_load_out,
   input wire logic irq_out
);
   import uart_lsf_pkg::*;
   logic q_en_reg;
   logic irq_en_reg;
   wire ls_rd = rd_in && addr_in == OFF_LINE_STATUS;
   // Shadow of queue enable and tx empty mask bit
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         q_en_reg <= 1'b0;
         irq_en_reg <= 1'b0;
      end else if (wr_in && addr_in == OFF_CTRL) begin
         q_en_reg <= wdata_in[CTRL_QUEUE_EN];
      end else if (wr_in && addr_in == OFF_INT_MASK) begin
         irq_en_reg <= wdata_in[LS_TX_EMPTY];
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_held;
      ls_rd && !q_en_reg ##1 rdata_out[LS_READY] && !rd_in && !wr_in;
   endsequence
   property p_load_ready; tx_load_out |-> tx_shift_ready_in; endproperty
   property p_wr_clears;
      wr_in && addr_in == OFF_DATA && !tx_load_out ##1 !tx_load_out ##1 ls_rd |=> !rdata_out[LS_TX_EMPTY];
   endproperty
   property p_load_sets; !q_en_reg && tx_load_out && !wr_in ##1 ls_rd |=> rdata_out[LS_TX_EMPTY]; endproperty
   property p_irq; ls_rd && irq_en_reg ##1 rdata_out[LS_TX_EMPTY] |-> $past(irq_out); endproperty
   property p_ready_rx; rx_done_in && !rd_in ##1 ls_rd |=> rdata_out[LS_READY]; endproperty
   property p_overrun; s_held ##1 rx_done_in ##1 ls_rd |=> rdata_out[LS_OVERRUN]; endproperty
   property p_rd_clears; ls_rd && !rx_done_in ##1 ls_rd |=> rdata_out[2:1] == 2'h0; endproperty
   property p_ready_clr;
      !q_en_reg && rd_in && addr_in == OFF_DATA && !rx_done_in ##1 ls_rd |=> !rdata_out[LS_READY];
   endproperty
   a_load_ready: assert property (p_load_ready)
      else $error("load while shifter busy");
   a_wr_clears: assert property (p_wr_clears)
      else $error("tx empty after write");
   a_load_sets: assert property (p_load_sets)
      else $error("tx empty not set by load");
   a_irq: assert property (p_irq)
      else $error("no irq with tx empty enabled");
   a_ready_rx: assert property (p_ready_rx)
      else $error("ready low after receive");
   a_overrun: assert property (p_overrun)
      else $error("overrun not flagged");
   a_rd_clears: assert property (p_rd_clears)
      else $error("error flags kept after read");
   a_ready_clr: assert property (p_ready_clr)
      else $error("ready high with nothing held");
endmodule
bind uart_line_status_flags uart_lsf_checker #(.QUEUE_DEPTH(QUEUE_DEPTH)) chk (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rx_done_in(rx_done_in),
   .tx_shift_ready_in(tx_shift_ready_in), .tx_load_out(tx_load_out), .irq_out(irq_out));

/* File: dv/uart_shifter_model.sv */
// Behavioural receive and transmit shifters beside the flag block.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/100ps
module uart_shifter_model #(
   parameter int HOLD = 3
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Transmit side
   input wire logic stall_in,
   input wire logic load_in,
   input wire logic [7:0] char_in,
   output logic ready_out,
   // Receive side
   output logic done_out = 1'b0,
   output logic [7:0] char_out = 8'h00,
   output logic parity_out = 1'b0,
   output logic stop_out = 1'b1,
   output logic serial_out = 1'b1
);
   int busy_cnt;
   logic [7:0] sent_q[$];
   // A sending shifter stays busy for HOLD cycles
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_cnt <= 0;
      end else if (load_in) begin
         busy_cnt <= HOLD;
         sent_q.push_back(char_in);
      end else if (busy_cnt > 0) begin
         busy_cnt <= busy_cnt - 1;
      end
   end
   assign ready_out = !rst_in && !stall_in && busy_cnt == 0;
   // Lines outside the strobe carry the inverse so stale data cannot pass
   task automatic send(input logic [7:0] c, input logic p, input logic s);
      char_out <= c;
      parity_out <= p;
      stop_out <= s;
      done_out <= 1'b1;
      @(posedge ref_clk_in);
      done_out <= 1'b0;
      char_out <= ~c;
      parity_out <= ~p;
      stop_out <= ~s;
   endtask
   task automatic line_low(input int n);
      serial_out <= 1'b0;
      repeat (n) @(posedge ref_clk_in);
      serial_out <= 1'b1;
   endtask
endmodule

/* File: dv/test_uart_line_status_flags.sv */
// Self-checking bench of the line status flag block.
// Assumes the shifter model on the far side and a reduced queue depth.
`timescale 1ns/100ps
module test_uart_line_status_flags;
   import uart_lsf_pkg::*;
   localparam int DEPTH = 8;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0, rd_in = 1'b0, stall = 1'b1;
   logic [7:0] rdata_out, rx_char, tx_char;
   logic rx_serial, rx_done, rx_par, rx_stop, tx_ready, tx_load, irq_out;
   int mismatches = 0, checks_done = 0, cycles = 0;
   logic [31:0] seed;
   uart_line_status_flags #(.QUEUE_DEPTH(DEPTH)) uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .rx_serial_in(rx_serial), .rx_done_in(rx_done), .rx_char_in(rx_char), .rx_parity_bit_in(rx_par),
      .rx_stop_bit_in(rx_stop), .tx_shift_ready_in(tx_ready), .tx_load_out(tx_load),
      .tx_char_out(tx_char), .irq_out(irq_out));
   uart_shifter_model sm (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .stall_in(stall), .load_in(tx_load),
      .char_in(tx_char), .ready_out(tx_ready), .done_out(rx_done), .char_out(rx_char),
      .parity_out(rx_par), .stop_out(rx_stop), .serial_out(rx_serial));
   always #4 ref_clk_in = ~ref_clk_in;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (mismatches == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         end_sim();
      end
   end
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
      // Spare edge so a following write never drives the strobe twice in one step
      @(posedge ref_clk_in);
   endtask
   task automatic rd2(input logic [2:0] a1, input logic [2:0] a2, output logic [7:0] d1, output logic [7:0] d2);
      addr_in <= a1;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      addr_in <= a2;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      d1 = rdata_out;
      @(posedge ref_clk_in);
      d2 = rdata_out;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      @(posedge ref_clk_in);
      d = rdata_out;
   endtask
   task automatic irq_is(input logic e);
      @(negedge ref_clk_in);
      check("irq", {7'h00, irq_out}, {7'h00, e});
      @(posedge ref_clk_in);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d, d2, c, e, st;
      logic [7:0] exp_q[$], st_q[$];
      int n0;
      seed = 32'h000159E8;
      repeat (8) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      @(posedge ref_clk_in);
      rd(OFF_LINE_STATUS, d); check("status reset", d, 8'h20);
      rd(OFF_INT_MASK, d); check("mask reset", d, INT_MASK_RST);
      rd(3'h7, d); check("unmapped", d, 8'h00);
      rd(OFF_FRAME_BITS, d); check("frame bits reset", d, {4'h0, FRAME_BITS_RST});
      // Single holding register with interrupt raise, mask and clear
      wr(OFF_INT_MASK, 8'h20);
      c = rnd();
      wr(OFF_DATA, c);
      rd(OFF_LINE_STATUS, d); check("tx empty held", d & 8'h20, 8'h00);
      wr(OFF_INT_STATUS, 8'hFF);
      irq_is(1'b0);
      stall <= 1'b0;
      @(posedge ref_clk_in);
      rd(OFF_LINE_STATUS, d); check("tx empty loaded", d & 8'h20, 8'h20);
      check("tx char", sm.sent_q[$], c);
      irq_is(1'b1);
      rd(OFF_INT_STATUS, d); check("tx empty event", d & 8'h20, 8'h20);
      wr(OFF_INT_MASK, 8'h00);
      irq_is(1'b0);
      wr(OFF_INT_STATUS, 8'hFF);
      // Five characters queued in the transmit queue while the shifter stalls
      wr(OFF_CTRL, 8'h01);
      stall <= 1'b1;
      n0 = sm.sent_q.size();
      exp_q = {};
      repeat (5) begin
         c = rnd();
         exp_q.push_back(c);
         wr(OFF_DATA, c);
      end
      rd(OFF_LINE_STATUS, d); check("tx queue busy", d & 8'h20, 8'h00);
      stall <= 1'b0;
      for (int i = 0; i < 60 && sm.sent_q.size() < n0 + 5; i++) @(posedge ref_clk_in);
      for (int i = 0; i < 5; i++) check("tx order", sm.sent_q[n0 + i], exp_q[i]);
      rd(OFF_LINE_STATUS, d); check("tx queue empty", d & 8'h20, 8'h20);
      // Received characters with parity and stop errors, both parity senses
      for (int m = 0; m < 2; m++) begin
         wr(OFF_CTRL, (m == 1) ? 8'h07 : 8'h03);
         repeat (3) begin
            c = rnd();
            e = rnd();
            st = 8'h21 | (e[0] ? 8'h04 : 8'h00) | (e[1] ? 8'h00 : 8'h08);
            exp_q.push_back(c);
            st_q.push_back(st);
            sm.send(c, ((m == 1) ? ^c : ~^c) ^ e[0], e[1]);
            @(posedge ref_clk_in);
         end
         exp_q = exp_q[exp_q.size() - 3:$];
         while (st_q.size() > 0) begin
            rd(OFF_LINE_STATUS, d); check("head flags", d & 8'h7F, st_q.pop_front());
            rd(OFF_DATA, d); check("rx char", d, exp_q.pop_front());
         end
         rd(OFF_LINE_STATUS, d); check("rx drained", d & 8'h01, 8'h00);
      end
      // Receive queue overfilled by one
      wr(OFF_CTRL, 8'h01);
      repeat (DEPTH + 1) begin
         c = rnd();
         exp_q.push_back(c);
         sm.send(c, 1'b0, 1'b1);
         @(posedge ref_clk_in);
      end
      rd(OFF_LINE_STATUS, d); check("queue overrun", d & 8'h03, 8'h03);
      for (int i = 0; i < DEPTH; i++) begin
         rd(OFF_DATA, d); check("kept char", d, exp_q[i]);
      end
      exp_q = {};
      // Single entry overrun, back-to-back reads
      wr(OFF_CTRL, 8'h00);
      c = rnd();
      sm.send(c, 1'b0, 1'b1);
      rd(OFF_LINE_STATUS, d); check("ready", d & 8'h03, 8'h01);
      sm.send(~c, 1'b0, 1'b1);
      rd2(OFF_LINE_STATUS, OFF_LINE_STATUS, d, d2);
      check("overrun", d & 8'h02, 8'h02);
      check("overrun cleared", d2 & 8'h02, 8'h00);
      rd2(OFF_DATA, OFF_LINE_STATUS, d, d2);
      check("first char kept", d, c);
      check("ready cleared", d2 & 8'h01, 8'h00);
      // Break: frame of 4 x 10 cycles
      wr(OFF_CTRL, 8'h01);
      wr(OFF_BIT_CYCLES, 8'h04);
      rd(OFF_BIT_CYCLES, d); check("bit cycles", d, 8'h04);
      sm.line_low(20);
      repeat (10) @(posedge ref_clk_in);
      rd(OFF_LINE_STATUS, d); check("short low", d & 8'h11, 8'h00);
      sm.line_low(120 + int'(rnd()));
      repeat (10) @(posedge ref_clk_in);
      rd(OFF_LINE_STATUS, d); check("break", d, 8'hB9);
      rd(OFF_DATA, d); check("break char", d, 8'h00);
      rd(OFF_LINE_STATUS, d); check("one break", d, 8'h20);
      end_sim();
   end
endmodule
